// file: verilog/pf_refresh_pkg.sv
// Constants for the power-fail synchroniser and standby refresh sequencer.
// Assumes a single 125 MHz system clock; all times are converted to cycles here.
package pf_refresh_pkg;

  // ************************************************************
  // Clock
  // ************************************************************
  localparam int CLK_PERIOD_NS = 8;

  // ************************************************************
  // Refresh timing, in their own units
  // ************************************************************
  localparam int PRETRIG_NS        = 3000;     // 3 us pretrigger
  localparam int CE_PULSE_NS       = 500;      // standby chip-enable pulse
  localparam int REFRESH_STEP_NS   = 62500;    // 62.5 us distributed spacing
  localparam int REFRESH_WINDOW_US = 2000;     // 2.0 ms for all rows

  // ************************************************************
  // Derived cycle counts
  // ************************************************************
  // Least times round up, longest times round down
  localparam int PRETRIG_CYCLES  = (PRETRIG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CE_PULSE_CYCLES = (CE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_STEP_CYCLES   = REFRESH_STEP_NS / CLK_PERIOD_NS;
  localparam int REFRESH_WINDOW_CYCLES = (REFRESH_WINDOW_US * 1000) / CLK_PERIOD_NS;

  // ************************************************************
  // Widths and counts
  // ************************************************************
  localparam int ROW_BITS     = 5;
  localparam int ROW_COUNT    = 32;
  localparam int PEND_BITS    = 6;
  localparam int PHASE_BITS   = 9;
  localparam int PERIOD_BITS  = 18;

  localparam logic [ROW_BITS-1:0]  ROW_RESET   = 5'h00;
  localparam logic [PEND_BITS-1:0] PEND_RESET  = 6'h00;
  localparam logic [PEND_BITS-1:0] PEND_FULL   = 6'h20;
  localparam logic [PEND_BITS-1:0] PEND_ONE    = 6'h01;
  localparam logic [PHASE_BITS-1:0] PHASE_ZERO = 9'h000;
  localparam logic [PHASE_BITS-1:0] PRETRIG_LAST =
    PHASE_BITS'(PRETRIG_CYCLES - 1);
  localparam logic [PHASE_BITS-1:0] CE_PULSE_LAST =
    PHASE_BITS'(CE_PULSE_CYCLES - 1);

  // ************************************************************
  // Refresh sequencer states, Gray along idle -> pretrigger -> pulse
  // ************************************************************
  typedef enum logic [1:0] {
    SEQ_IDLE    = 2'h0,
    SEQ_PRETRIG = 2'h1,
    SEQ_PULSE   = 2'h3
  } seq_state_t;

endpackage : pf_refresh_pkg

// file: verilog/power_fail_refresh_sync.sv
// Power-fail synchroniser, refresh sequencer and chip-enable selector for a
// battery-backed dynamic memory array.
// Assumes power_fail and mem_clk arrive asynchronously on pins; burst_mode is a
// level from logic on clk.
//
// Summary of operation
// - End of standby pulse clears guard flop.
// - Mode flop takes power_fail on memory clock edge.
// - Battery mode routes standby pulse to enables.
// - Battery mode removes power from unneeded logic.
// - Pretrigger sets guard, guard blocks mode change.
// - Pretrigger end launches 500 ns enable pulse.
// - No power-fail change aborts access or refresh.
// - 32 rows every 2 ms, burst or distributed.
`timescale 1ns/1ps
`default_nettype none

module power_fail_refresh_sync #(
  parameter int REFRESH_STEP_CYCLES   = pf_refresh_pkg::REFRESH_STEP_CYCLES,
  parameter int REFRESH_WINDOW_CYCLES = pf_refresh_pkg::REFRESH_WINDOW_CYCLES
) (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              power_fail,
  input  wire logic                              mem_clk,
  input  wire logic                              burst_mode,
  output logic                                   battery_mode,
  output logic                                   battery_mode_n,
  output logic                                   refresh_guard,
  output logic                                   chip_enable,
  output logic                                   logic_power_en,
  output logic                                   refresh_active,
  output logic [pf_refresh_pkg::ROW_BITS-1:0]    refresh_row
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic pf_meta;
  logic pf_sync;
  logic mclk_meta;
  logic mclk_sync;
  logic mclk_prev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pf_meta   <= 1'b0;
      pf_sync   <= 1'b0;
      mclk_meta <= 1'b0;
      mclk_sync <= 1'b0;
      mclk_prev <= 1'b0;
    end else begin
      pf_meta   <= power_fail;
      pf_sync   <= pf_meta;
      mclk_meta <= mem_clk;
      mclk_sync <= mclk_meta;
      mclk_prev <= mclk_sync;
    end
  end

  // Rising memory clock edge, seen only after both sync stages
  logic mclk_rise;
  assign mclk_rise = mclk_sync & ~mclk_prev;

  // ************************************************************
  // Refresh request timer
  // ************************************************************
  // Distributed mode asks for one row per step; burst mode asks for all
  // rows at once per window. The shared counter restarts on a mode change.
  logic [pf_refresh_pkg::PERIOD_BITS-1:0] period_cnt;
  logic                                   burst_prev;
  logic                                   period_tick;
  logic [pf_refresh_pkg::PERIOD_BITS-1:0] period_last;

  assign period_last = burst_mode ?
    pf_refresh_pkg::PERIOD_BITS'(REFRESH_WINDOW_CYCLES - 1) :
    pf_refresh_pkg::PERIOD_BITS'(REFRESH_STEP_CYCLES - 1);
  assign period_tick = (period_cnt == period_last) && (burst_mode == burst_prev);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt <= '0;
      burst_prev <= 1'b0;
    end else begin
      burst_prev <= burst_mode;
      if (period_tick || (burst_mode != burst_prev)) begin
        period_cnt <= '0;
      end else begin
        period_cnt <= period_cnt + 1'b1;
      end
    end
  end

  // ************************************************************
  // Pending refresh cycles
  // ************************************************************
  pf_refresh_pkg::seq_state_t             state;
  logic [pf_refresh_pkg::PHASE_BITS-1:0]  phase;
  logic                                   pulse_done;
  logic                                   pretrig_done;
  logic [pf_refresh_pkg::PEND_BITS-1:0]   pending;

  assign pretrig_done = (state == pf_refresh_pkg::SEQ_PRETRIG) &&
                        (phase == pf_refresh_pkg::PRETRIG_LAST);
  assign pulse_done   = (state == pf_refresh_pkg::SEQ_PULSE) &&
                        (phase == pf_refresh_pkg::CE_PULSE_LAST);

  // A burst request wins over the completion in the same cycle; a distributed one cancels it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= pf_refresh_pkg::PEND_RESET;
    end else if (period_tick && burst_mode) begin
      pending <= pf_refresh_pkg::PEND_FULL;
    end else if (period_tick && !pulse_done) begin
      if (pending != pf_refresh_pkg::PEND_FULL) begin
        pending <= pending + pf_refresh_pkg::PEND_ONE;
      end
    end else if (!period_tick && pulse_done) begin
      pending <= pending - pf_refresh_pkg::PEND_ONE;
    end
  end

  // ************************************************************
  // Refresh sequencer: pretrigger then chip-enable pulse
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pf_refresh_pkg::SEQ_IDLE;
      phase <= pf_refresh_pkg::PHASE_ZERO;
    end else begin
      case (state)
        pf_refresh_pkg::SEQ_IDLE: begin
          phase <= pf_refresh_pkg::PHASE_ZERO;
          if (pending != pf_refresh_pkg::PEND_RESET) begin
            state <= pf_refresh_pkg::SEQ_PRETRIG;
          end
        end
        pf_refresh_pkg::SEQ_PRETRIG: begin
          if (pretrig_done) begin
            state <= pf_refresh_pkg::SEQ_PULSE;
            phase <= pf_refresh_pkg::PHASE_ZERO;
          end else begin
            phase <= phase + 1'b1;
          end
        end
        pf_refresh_pkg::SEQ_PULSE: begin
          if (pulse_done) begin
            state <= pf_refresh_pkg::SEQ_IDLE;
            phase <= pf_refresh_pkg::PHASE_ZERO;
          end else begin
            phase <= phase + 1'b1;
          end
        end
        default: begin
          state <= pf_refresh_pkg::SEQ_IDLE;
          phase <= pf_refresh_pkg::PHASE_ZERO;
        end
      endcase
    end
  end

  // ************************************************************
  // Row address
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_row <= pf_refresh_pkg::ROW_RESET;
    end else if (pulse_done) begin
      refresh_row <= refresh_row + 1'b1;
    end
  end

  // ************************************************************
  // Guard flop
  // ************************************************************
  // Held from pretrigger start through the end of the enable pulse, so a
  // power-fail change never lands inside a refresh cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_guard <= 1'b0;
    end else if (state == pf_refresh_pkg::SEQ_IDLE &&
                 pending != pf_refresh_pkg::PEND_RESET) begin
      refresh_guard <= 1'b1;
    end else if (pulse_done) begin
      refresh_guard <= 1'b0;
    end
  end

  // ************************************************************
  // Mode flop
  // ************************************************************
  // J = power_fail, K = its complement: it follows the level, but only on a
  // memory clock edge, so a running access is never cut short.
  logic jk_j;
  logic jk_k;
  logic next_battery_mode;

  assign jk_j = pf_sync;
  assign jk_k = ~pf_sync;

  always_comb begin
    case ({jk_j, jk_k})
      2'h2:    next_battery_mode = 1'b1;
      2'h1:    next_battery_mode = 1'b0;
      2'h3:    next_battery_mode = ~battery_mode;
      default: next_battery_mode = battery_mode;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      battery_mode   <= 1'b0;
      battery_mode_n <= 1'b1;
    end else if (mclk_rise && !refresh_guard) begin
      battery_mode   <= next_battery_mode;
      battery_mode_n <= ~next_battery_mode;
    end
  end

  // ************************************************************
  // Chip-enable selection and standby power
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chip_enable    <= 1'b0;
      logic_power_en <= 1'b1;
      refresh_active <= 1'b0;
    end else begin
      refresh_active <= (state == pf_refresh_pkg::SEQ_PULSE);
      if (battery_mode) begin
        chip_enable <= (state == pf_refresh_pkg::SEQ_PULSE);
      end else begin
        chip_enable <= mclk_sync;
      end
      logic_power_en <= ~battery_mode;
    end
  end

endmodule : power_fail_refresh_sync

`default_nettype wire

// file: verif/power_fail_refresh_sync_checker.sv
// Checker for the power-fail synchroniser and standby refresh sequencer.
// Sees only the top module ports; bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module power_fail_refresh_sync_checker (
  input wire logic                           clk,
  input wire logic                           rst_n,
  input wire logic                           power_fail,
  input wire logic                           mem_clk,
  input wire logic                           battery_mode,
  input wire logic                           battery_mode_n,
  input wire logic                           refresh_guard,
  input wire logic                           chip_enable,
  input wire logic                           logic_power_en,
  input wire logic                           refresh_active,
  input wire logic [pf_refresh_pkg::ROW_BITS-1:0] refresh_row
);
  logic [9:0] guard_cnt;
  logic [9:0] act_cnt;
  // ****
  // High-time counters
  // ****
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      guard_cnt <= 10'h000;
      act_cnt   <= 10'h000;
    end else begin
      guard_cnt <= refresh_guard ? guard_cnt + 10'h001 : 10'h000;
      act_cnt   <= refresh_active ? act_cnt + 10'h001 : 10'h000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_reset_state:
    assert property ($rose(rst_n) |-> !battery_mode && !refresh_guard && logic_power_en) else $error("bad reset state");
  chk_mode_pair:
    assert property (battery_mode_n != battery_mode) else $error("mode outputs not complementary");
  chk_mode_source:
    assert property ($changed(battery_mode) |-> battery_mode == $past(power_fail, 3)) else $error("mode not from power fail");
  chk_guard_blocks:
    assert property ($changed(battery_mode) |-> !$past(refresh_guard)) else $error("mode changed under guard");
  chk_power_off:
    assert property (logic_power_en == !$past(battery_mode)) else $error("logic power not following mode");
  chk_guard_len:
    assert property ($fell(refresh_guard) |-> guard_cnt == 10'(pf_refresh_pkg::PRETRIG_CYCLES + pf_refresh_pkg::CE_PULSE_CYCLES))
      else $error("guard length wrong");
  chk_pulse_end:
    assert property ($fell(refresh_guard) |-> refresh_active ##1 !refresh_active) else $error("pulse end not at guard clear");
  chk_pulse_len:
    assert property ($fell(refresh_active) |-> act_cnt == 10'(pf_refresh_pkg::CE_PULSE_CYCLES)) else $error("pulse length wrong");
  chk_standby_ce:
    assert property (battery_mode && $past(battery_mode) |-> chip_enable == refresh_active) else $error("standby enable wrong");
  chk_oper_ce:
    assert property ((!mem_clk && !battery_mode) [*5] |-> !chip_enable) else $error("enable without memory clock");
  chk_row_step:
    assert property ($changed(refresh_row) |-> $fell(refresh_guard) && refresh_row == $past(refresh_row) + 5'h01)
      else $error("row step wrong");
endmodule : power_fail_refresh_sync_checker
`default_nettype wire

// file: verif/mem_clk_source.sv
// Processor clock model: drives the external memory clock.
// Assumes the bench clock; stopped clock rests low.
`timescale 1ns/1ps
`default_nettype none
module mem_clk_source (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic slow,
  output logic      mem_clk
);
  logic [4:0] count;
  // Halves of 4 or 12 clks keep each level past the 3-clk detect limit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count   <= 5'h00;
      mem_clk <= 1'b0;
    end else if (!run) begin
      count   <= 5'h00;
      mem_clk <= 1'b0;
    end else if (count == (slow ? 5'h0B : 5'h03)) begin
      count   <= 5'h00;
      mem_clk <= ~mem_clk;
    end else begin
      count <= count + 5'h01;
    end
  end
endmodule : mem_clk_source
`default_nettype wire

// file: verif/power_fail_refresh_sync_tb_top.sv
// Self-checking bench for the power-fail synchroniser.
// Assumes the package, design, clock model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module power_fail_refresh_sync_tb_top;
  localparam int STEP = 600;
  logic       clk = 1'b0, rst_n = 1'b0, power_fail = 1'b0, burst_mode = 1'b0, run = 1'b0, slow = 1'b0;
  wire logic  mem_clk;
  logic       battery_mode, battery_mode_n, refresh_guard, chip_enable, logic_power_en, refresh_active;
  logic [4:0] refresh_row;
  int         fails = 0;
  int         check_count = 0;
  always #4 clk = ~clk;
  mem_clk_source mem_clk_source_i (.clk(clk), .rst_n(rst_n), .run(run), .slow(slow), .mem_clk(mem_clk));
  power_fail_refresh_sync #(.REFRESH_STEP_CYCLES(STEP), .REFRESH_WINDOW_CYCLES(20000)) power_fail_refresh_sync_i (
    .clk(clk), .rst_n(rst_n), .power_fail(power_fail), .mem_clk(mem_clk), .burst_mode(burst_mode),
    .battery_mode(battery_mode), .battery_mode_n(battery_mode_n), .refresh_guard(refresh_guard),
    .chip_enable(chip_enable), .logic_power_en(logic_power_en), .refresh_active(refresh_active),
    .refresh_row(refresh_row));
  // ****
  // Tasks
  // ****
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic wait_guard(logic lvl);
    int n;
    n = 0;
    while (refresh_guard !== lvl && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n == 2000) begin
      fails++;
      wrap_up();
    end
  endtask : wait_guard
  // Counts guard clears and enable-high cycles over a span
  task automatic watch(int cyc, output int nf, output int nc);
    logic prev;
    nf = 0;
    nc = 0;
    prev = refresh_guard;
    repeat (cyc) begin
      @(negedge clk);
      nf += int'(prev === 1'b1 && refresh_guard === 1'b0);
      nc += int'(chip_enable === 1'b1);
      prev = refresh_guard;
    end
  endtask : watch
  function automatic int exp_falls(int cyc, logic burst);
    return burst ? 32 : cyc / STEP;
  endfunction : exp_falls
  task automatic set_pf(logic v);
    @(posedge clk);
    power_fail <= v;
    repeat (1500) @(negedge clk);
  endtask : set_pf
  // ****
  // Sequence
  // ****
  initial begin
    int f, c;
    logic [4:0] r0;
    logic pf;
    void'($urandom(78));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("battery_mode", battery_mode, 0);
    check("logic_power_en", logic_power_en, 1);
    check("refresh_row", refresh_row, 0);
    $display("Test reset done");
    wait_guard(1);
    wait_guard(0);
    r0 = refresh_row;
    watch(5700, f, c);
    check("falls", f, exp_falls(5700, 0));
    check("row", refresh_row, 5'(r0 + exp_falls(5700, 0)));
    check("ce_stopped", c, 0);
    $display("Test distributed done");
    run <= 1'b1;
    repeat (6) begin
      pf = 1'($urandom_range(0, 1));
      slow <= 1'($urandom_range(0, 1));
      set_pf(pf);
      repeat ($urandom_range(0, 800)) @(negedge clk);
      check("battery_mode", battery_mode, pf);
      check("battery_mode_n", battery_mode_n, !pf);
      check("logic_power_en", logic_power_en, !pf);
      // Settled clock model: 48 clks hold whole periods, half of them high
      if (!pf) begin
        watch(48, f, c);
        check("oper_ce", c, 24);
      end
    end
    $display("Test random mode done");
    set_pf(1'b1);
    wait_guard(0);
    wait_guard(1);
    @(posedge clk);
    power_fail <= 1'b0;
    repeat (400) @(negedge clk);
    check("held_mode", battery_mode, 1);
    wait_guard(0);
    repeat (100) @(negedge clk);
    check("late_mode", battery_mode, 0);
    $display("Test guard block done");
    set_pf(1'b1);
    wait_guard(1);
    wait_guard(0);
    watch(700, f, c);
    check("standby_ce", c, pf_refresh_pkg::CE_PULSE_CYCLES);
    $display("Test standby done");
    set_pf(1'b0);
    wait_guard(1);
    wait_guard(0);
    r0 = refresh_row;
    @(posedge clk);
    burst_mode <= 1'b1;
    watch(36000, f, c);
    check("burst_falls", f, exp_falls(36000, 1));
    check("burst_row", refresh_row, 5'(r0 + exp_falls(36000, 1)));
    $display("Test burst done");
    wrap_up();
  end
endmodule : power_fail_refresh_sync_tb_top
bind power_fail_refresh_sync power_fail_refresh_sync_checker power_fail_refresh_sync_checker_i (
  .clk(clk), .rst_n(rst_n), .power_fail(power_fail), .mem_clk(mem_clk), .battery_mode(battery_mode),
  .battery_mode_n(battery_mode_n), .refresh_guard(refresh_guard), .chip_enable(chip_enable),
  .logic_power_en(logic_power_en), .refresh_active(refresh_active), .refresh_row(refresh_row));
`default_nettype wire
